// ===== hdl/bds_pkg.sv
// Purpose: shared constants for the background debug serial port
// Assumes: core clock 10 MHz, link clock made by the host end
// Notes: command word layout is opcode in [15:12], address/mask below
package bds_pkg;
  localparam int WORD_W = 16;
  localparam int FRAME_W = 17;
  localparam int STAT_BIT = 16;
  localparam int ADDR_W = 20;
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  // status bit values in target frames, control bit value in host frames
  localparam logic STAT_OK = 1'h0;
  localparam logic STAT_NODATA = 1'h1;
  localparam logic HOST_CTRL = 1'h0;
  // resume address offset
  localparam logic [19:0] RESUME_OFS = 20'h00006;
  // link timing for the host divider
  localparam real SYS_CLK_NS = 100.0;
  localparam real LCLK_HALF_NS = 400.0;
  localparam int LCLK_HALF_CYC = int'(LCLK_HALF_NS / SYS_CLK_NS);
  localparam real FRAME_GAP_NS = 1600.0;
  localparam int FRAME_GAP_CYC = int'(FRAME_GAP_NS / SYS_CLK_NS);
  localparam int BIT_CNT_W = 5;
  localparam int DIV_W = 8;

  typedef enum logic [3:0] {
    BDS_NULL = 4'h0,
    BDS_RD_REGS = 4'h1,
    BDS_WR_REGS = 4'h2,
    BDS_RD_MACC = 4'h3,
    BDS_WR_MACC = 4'h4,
    BDS_RD_PCSP = 4'h5,
    BDS_WR_PCSP = 4'h6,
    BDS_RD_DATA = 4'h7,
    BDS_WR_DATA = 4'h8,
    BDS_RD_PROG = 4'h9,
    BDS_WR_PROG = 4'ha,
    BDS_RESUME = 4'hb
  } bds_cmd_e;

  // extension words that follow the operation word
  function automatic logic [1:0] bds_ext_count(input logic [3:0] op);
    case (op)
      BDS_WR_REGS, BDS_WR_MACC, BDS_RD_DATA, BDS_RD_PROG: return 2'h1;
      BDS_WR_PCSP, BDS_WR_DATA, BDS_WR_PROG: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction : bds_ext_count

  function automatic logic bds_has_result(input logic [3:0] op);
    case (op)
      BDS_RD_REGS, BDS_RD_MACC, BDS_RD_PCSP, BDS_RD_DATA,
      BDS_RD_PROG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : bds_has_result
endpackage : bds_pkg

// ===== hdl/bds_link_if.sv
// Purpose: pins between the debug target and the development system
// Assumes: host drives the serial input pin whenever it runs
// Notes: pipe_track_1 wire level is resolved here from the device enable
`timescale 1ns/100ps
interface bds_link_if;
  logic debug_serial_clock;
  logic pipe_track_0;
  logic pt1_dev_out;
  logic pt1_dev_oe;
  logic pt1_host_out;
  logic pipe_track_1;
  logic halted;
  logic breakpoint_request_n;

  // device drives tracking data when enabled, host serial data otherwise
  assign pipe_track_1 = pt1_dev_oe ? pt1_dev_out : pt1_host_out;

  modport dev (
    input debug_serial_clock,
    input pipe_track_1,
    input breakpoint_request_n,
    output pipe_track_0,
    output pt1_dev_out,
    output pt1_dev_oe,
    output halted
  );
  modport host (
    output debug_serial_clock,
    output pt1_host_out,
    output breakpoint_request_n,
    input pipe_track_0,
    input halted
  );
endinterface : bds_link_if

// ===== hdl/bds_target.sv
// Purpose: debug state control and serial slave of the target core
// Assumes: link clock idles high and only runs while halted
// Notes: serial shifting runs on the link clock, commands on sys_clk
`timescale 1ns/100ps
module bds_target (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  bds_link_if.dev link,
  input wire logic instr_boundary,
  input wire logic enter_debug_instruction,
  input wire logic [1:0] track_code,
  input wire logic [bds_pkg::ADDR_W-1:0] extended_program_counter,
  output logic exec_stall,
  output logic brk_exception,
  output logic resume_pulse,
  output logic [bds_pkg::ADDR_W-1:0] resume_addr,
  output logic core_req,
  output logic [bds_pkg::WORD_W-1:0] core_cmd,
  output logic [bds_pkg::WORD_W-1:0] core_ext0,
  output logic [bds_pkg::WORD_W-1:0] core_ext1,
  input wire logic core_ack,
  input wire logic [bds_pkg::WORD_W-1:0] core_rdata
);
  import bds_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_EXEC = 2'b10
  } bds_state_e;

  bds_state_e state_r;
  logic halted_r;
  logic dbg_en_r;
  logic srst_d_r;
  logic brk_s1_r;
  logic brk_s2_r;
  logic [1:0] ext_left_r;
  logic ext_idx_r;
  logic [WORD_W-1:0] cmd_r;
  logic [WORD_W-1:0] ext0_r;
  logic [WORD_W-1:0] ext1_r;
  logic [FRAME_W-1:0] tx_word_r;
  logic req_r;
  logic exc_r;
  logic res_r;
  logic [ADDR_W-1:0] res_addr_r;
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic rx_evt;
  logic [3:0] op_in;
  // link clock domain
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [WORD_W-1:0] rx_sh_r;
  logic [WORD_W-1:0] rx_hold_r;
  logic rx_tgl_r;
  logic [FRAME_W-1:0] tx_sh_r;
  logic sout_r;

  //--------------------------------------------------------------
  // debug enable strap
  //--------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      brk_s1_r <= link.breakpoint_request_n;
      brk_s2_r <= brk_s1_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      srst_d_r <= srst;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (srst_d_r && !srst) begin
        dbg_en_r <= ~brk_s2_r;
      end
    end
  end

  //--------------------------------------------------------------
  // word arrival from the link domain
  //--------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      rx_s1_r <= rx_tgl_r;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  assign rx_evt = rx_s2_r ^ rx_s3_r;
  assign op_in = rx_hold_r[OP_HI:OP_LO];

  //--------------------------------------------------------------
  // debug state machine
  //--------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_RUN;
      halted_r <= 1'b0;
      ext_left_r <= 2'h0;
      ext_idx_r <= 1'b0;
      cmd_r <= 16'h0000;
      ext0_r <= 16'h0000;
      ext1_r <= 16'h0000;
      tx_word_r <= {STAT_NODATA, 16'h0000};
      req_r <= 1'b0;
      exc_r <= 1'b0;
      res_r <= 1'b0;
      res_addr_r <= 20'h00000;
    end else if (ce) begin
      exc_r <= 1'b0;
      res_r <= 1'b0;
      case (state_r)
        ST_RUN: begin
          if (instr_boundary && (!brk_s2_r || enter_debug_instruction))
          begin
            if (dbg_en_r) begin
              state_r <= ST_HALT;
              halted_r <= 1'b1;
              ext_left_r <= 2'h0;
              tx_word_r <= {STAT_NODATA, 16'h0000};
            end else if (!brk_s2_r) begin
              exc_r <= 1'b1;
            end
          end
        end
        ST_HALT: begin
          if (rx_evt) begin
            if (ext_left_r == 2'h0) begin
              cmd_r <= rx_hold_r;
              ext_idx_r <= 1'b0;
              ext_left_r <= bds_ext_count(op_in);
              tx_word_r <= {STAT_NODATA, 16'h0000};
              if (bds_ext_count(op_in) == 2'h0) begin
                if (op_in == BDS_RESUME) begin
                  state_r <= ST_RUN;
                  halted_r <= 1'b0;
                  res_r <= 1'b1;
                  res_addr_r <= extended_program_counter - RESUME_OFS;
                end else if (op_in != BDS_NULL) begin
                  state_r <= ST_EXEC;
                  req_r <= 1'b1;
                end
              end
            end else begin
              if (ext_idx_r) begin
                ext1_r <= rx_hold_r;
              end else begin
                ext0_r <= rx_hold_r;
              end
              ext_idx_r <= 1'b1;
              ext_left_r <= ext_left_r - 2'h1;
              if (ext_left_r == 2'h1) begin
                state_r <= ST_EXEC;
                req_r <= 1'b1;
              end
            end
          end
        end
        ST_EXEC: begin
          if (core_ack) begin
            req_r <= 1'b0;
            state_r <= ST_HALT;
            if (bds_has_result(cmd_r[OP_HI:OP_LO])) begin
              tx_word_r <= {STAT_OK, core_rdata};
            end
          end
        end
        default: begin
          state_r <= ST_RUN;
          halted_r <= 1'b0;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // serial shifter on the link clock, cleared while not halted
  //--------------------------------------------------------------
  always_ff @(posedge link.debug_serial_clock or negedge halted_r) begin
    if (!halted_r) begin
      bit_cnt_r <= 5'h00;
      rx_sh_r <= 16'h0000;
      rx_hold_r <= 16'h0000;
      rx_tgl_r <= 1'b0;
    end else begin
      rx_sh_r <= {rx_sh_r[WORD_W-2:0], link.pipe_track_1};
      if (bit_cnt_r == 5'(FRAME_W - 1)) begin
        bit_cnt_r <= 5'h00;
        rx_hold_r <= {rx_sh_r[WORD_W-2:0], link.pipe_track_1};
        rx_tgl_r <= ~rx_tgl_r;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // tx_word_r is read only at the first fall of a frame; the host gap
  // keeps it still by then, so the word needs no further crossing
  always_ff @(negedge link.debug_serial_clock or negedge halted_r) begin
    if (!halted_r) begin
      tx_sh_r <= 17'h00000;
      sout_r <= 1'b0;
    end else if (bit_cnt_r == 5'h00) begin
      sout_r <= tx_word_r[STAT_BIT];
      tx_sh_r <= {tx_word_r[FRAME_W-2:0], 1'b0};
    end else begin
      sout_r <= tx_sh_r[FRAME_W-1];
      tx_sh_r <= {tx_sh_r[FRAME_W-2:0], 1'b0};
    end
  end

  //--------------------------------------------------------------
  // pins and core side outputs
  //--------------------------------------------------------------
  assign link.pipe_track_0 = halted_r ? sout_r : track_code[0];
  assign link.pt1_dev_out = track_code[1];
  assign link.pt1_dev_oe = ~halted_r;
  assign link.halted = halted_r;
  assign exec_stall = halted_r;
  assign brk_exception = exc_r;
  assign resume_pulse = res_r;
  assign resume_addr = res_addr_r;
  assign core_req = req_r;
  assign core_cmd = cmd_r;
  assign core_ext0 = ext0_r;
  assign core_ext1 = ext1_r;
endmodule : bds_target

// ===== hdl/bds_host.sv
// Purpose: development system end, master of the debug serial link
// Assumes: one frame per accepted word, frames spaced by a gap
// Notes: serial clock made by dividing sys_clk
`timescale 1ns/100ps
module bds_host (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  bds_link_if.host link,
  input wire logic brk_request,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [bds_pkg::WORD_W-1:0] tx_word,
  output logic rx_valid,
  output logic [bds_pkg::FRAME_W-1:0] rx_frame,
  output logic target_halted
);
  import bds_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_HIGH = 2'b10,
    HS_GAP = 2'b11
  } bds_hstate_e;

  bds_hstate_e state_r;
  logic [DIV_W-1:0] div_r;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [FRAME_W-1:0] out_sh_r;
  logic [FRAME_W-1:0] in_sh_r;
  logic sclk_r;
  logic dsi_r;
  logic rxv_r;
  logic [FRAME_W-1:0] rxf_r;
  logic hlt_s1_r;
  logic hlt_s2_r;
  logic sout_s1_r;
  logic sout_s2_r;

  //--------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      hlt_s1_r <= link.halted;
      hlt_s2_r <= hlt_s1_r;
      sout_s1_r <= link.pipe_track_0;
      sout_s2_r <= sout_s1_r;
    end
  end

  //--------------------------------------------------------------
  // frame engine
  //--------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= HS_IDLE;
      div_r <= 8'h00;
      bit_cnt_r <= 5'h00;
      out_sh_r <= 17'h00000;
      in_sh_r <= 17'h00000;
      sclk_r <= 1'b1;
      dsi_r <= 1'b0;
      rxv_r <= 1'b0;
      rxf_r <= 17'h00000;
    end else if (ce) begin
      rxv_r <= 1'b0;
      case (state_r)
        HS_IDLE: begin
          if (tx_valid && hlt_s2_r) begin
            // status/control bit leads and is always clear
            out_sh_r <= {HOST_CTRL, tx_word};
            bit_cnt_r <= 5'h00;
            sclk_r <= 1'b0;
            dsi_r <= HOST_CTRL;
            div_r <= 8'h00;
            state_r <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (div_r == 8'(LCLK_HALF_CYC - 1)) begin
            div_r <= 8'h00;
            sclk_r <= 1'b1;
            state_r <= HS_HIGH;
          end else begin
            div_r <= div_r + 8'h01;
          end
        end
        HS_HIGH: begin
          if (div_r == 8'(LCLK_HALF_CYC - 1)) begin
            div_r <= 8'h00;
            // target data settled since the falling edge
            in_sh_r <= {in_sh_r[FRAME_W-2:0], sout_s2_r};
            if (bit_cnt_r == 5'(FRAME_W - 1)) begin
              rxv_r <= 1'b1;
              rxf_r <= {in_sh_r[FRAME_W-2:0], sout_s2_r};
              state_r <= HS_GAP;
            end else begin
              bit_cnt_r <= bit_cnt_r + 5'h01;
              sclk_r <= 1'b0;
              dsi_r <= out_sh_r[FRAME_W-2];
              out_sh_r <= {out_sh_r[FRAME_W-2:0], 1'b0};
              state_r <= HS_LOW;
            end
          end else begin
            div_r <= div_r + 8'h01;
          end
        end
        HS_GAP: begin
          // room for the target to post its result
          if (div_r == 8'(FRAME_GAP_CYC - 1)) begin
            div_r <= 8'h00;
            state_r <= HS_IDLE;
          end else begin
            div_r <= div_r + 8'h01;
          end
        end
        default: begin
          state_r <= HS_IDLE;
          sclk_r <= 1'b1;
        end
      endcase
    end
  end

  assign tx_ready = (state_r == HS_IDLE) && hlt_s2_r;
  assign rx_valid = rxv_r;
  assign rx_frame = rxf_r;
  assign target_halted = hlt_s2_r;
  assign link.debug_serial_clock = sclk_r;
  assign link.pt1_host_out = dsi_r;
  assign link.breakpoint_request_n = ~brk_request;
endmodule : bds_host

// ===== tb/bds_link_asserts.sv
// Purpose: link checks for the debug serial port
// Assumes: one sys_clk domain, srst sync active high
// Notes: a frame starts at a link clock fall after a long high
`timescale 1ns/100ps
module bds_link_asserts (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic debug_serial_clock,
  input wire logic pipe_track_0,
  input wire logic pt1_dev_oe,
  input wire logic pipe_track_1,
  input wire logic halted
);
  logic sclk_q_r;
  logic [4:0] hi_cnt_r;
  logic [4:0] fall_cnt_r;
  logic fell_now;
  logic frame_start;
  assign fell_now = sclk_q_r && !debug_serial_clock;
  assign frame_start = fell_now && (hi_cnt_r >= 5'h08);
  // length of the current high phase of the link clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclk_q_r <= 1'b1;
      hi_cnt_r <= 5'h1f;
    end else begin
      sclk_q_r <= debug_serial_clock;
      if (!debug_serial_clock) begin
        hi_cnt_r <= 5'h00;
      end else if (hi_cnt_r != 5'h1f) begin
        hi_cnt_r <= hi_cnt_r + 5'h01;
      end
    end
  end
  // falling edges seen in the current frame
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fall_cnt_r <= 5'h00;
    end else if (frame_start) begin
      fall_cnt_r <= 5'h01;
    end else if (fell_now) begin
      fall_cnt_r <= fall_cnt_r + 5'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence low_phase;
    !debug_serial_clock [*4] ##1 debug_serial_clock;
  endsequence
  sequence high_phase;
    debug_serial_clock [*4] ##1 !debug_serial_clock;
  endsequence
  a_low_phase:
    assert property ($fell(debug_serial_clock) |-> low_phase)
    else $error("link clock low phase wrong");
  a_high_phase:
    assert property ($rose(debug_serial_clock) && fall_cnt_r != 5'h11
      |-> high_phase) else $error("link clock high phase wrong");
  a_clock_idle:
    assert property (!halted |-> debug_serial_clock)
    else $error("link clock runs while not halted");
  a_no_early:
    assert property (frame_start |-> halted && $past(halted, 2))
    else $error("frame started before halt");
  a_host_bit16:
    assert property (frame_start |-> !pipe_track_1)
    else $error("host status bit not zero");
  a_frame_len:
    assert property (frame_start |-> fall_cnt_r == 5'h00
      || fall_cnt_r == 5'h11) else $error("frame not 17 bits");
  a_out_stable:
    assert property (halted && $rose(debug_serial_clock)
      |-> $stable(pipe_track_0) ##1 $stable(pipe_track_0))
    else $error("serial out moved near rising edge");
  a_pins_swap:
    assert property (halted |-> !pt1_dev_oe)
    else $error("target drives pin while halted");
  a_pins_back:
    assert property (!halted |-> pt1_dev_oe)
    else $error("tracking pin not driven while running");
endmodule : bds_link_asserts

// ===== tb/testbench.sv
// Purpose: bench for the debug target and host across the link
// Assumes: sys_clk 100 ns, the host divides it for the link clock
// Notes: a small core model acks each command request
`timescale 1ns/100ps
module testbench;
  import bds_pkg::*;
  localparam logic [23:0] EXT_TBL = 24'h266110;
  localparam logic [11:0] RD_TBL = 12'h2aa;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic instr_boundary = 1'b0;
  logic enter_debug_instruction = 1'b0;
  logic [1:0] track_code = 2'h1;
  logic [19:0] epc = 20'h12345;
  logic core_ack = 1'b0;
  logic [15:0] core_rdata = 16'h0000;
  logic brk_request = 1'b0;
  logic tx_valid = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic exec_stall, brk_exception, resume_pulse, core_req;
  logic tx_ready, rx_valid, target_halted, have_exp;
  logic [19:0] resume_addr, res_addr;
  logic [15:0] core_cmd, core_ext0, core_ext1, got_cmd, got_ext0, got_ext1;
  logic [16:0] rx_frame, exp_rx;
  int bad_count = 0;
  int check_count = 0;
  int exc_cnt = 0;
  int res_cnt = 0;
  bds_link_if link_i ();
  bds_target u_bds_target (.sys_clk(sys_clk), .srst(srst), .ce(1'b1),
    .link(link_i.dev), .instr_boundary(instr_boundary),
    .enter_debug_instruction(enter_debug_instruction),
    .track_code(track_code), .extended_program_counter(epc),
    .exec_stall(exec_stall), .brk_exception(brk_exception),
    .resume_pulse(resume_pulse), .resume_addr(resume_addr),
    .core_req(core_req), .core_cmd(core_cmd), .core_ext0(core_ext0),
    .core_ext1(core_ext1), .core_ack(core_ack), .core_rdata(core_rdata));
  bds_host u_bds_host (.sys_clk(sys_clk), .srst(srst), .ce(1'b1),
    .link(link_i.host), .brk_request(brk_request),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
    .rx_valid(rx_valid), .rx_frame(rx_frame),
    .target_halted(target_halted));
  bds_link_asserts u_bds_link_asserts (.sys_clk(sys_clk), .srst(srst),
    .debug_serial_clock(link_i.debug_serial_clock),
    .pipe_track_0(link_i.pipe_track_0), .pt1_dev_oe(link_i.pt1_dev_oe),
    .pipe_track_1(link_i.pipe_track_1), .halted(link_i.halted));
  always #50 sys_clk = ~sys_clk;
  // core model: one ack per request, pulse counters
  always @(posedge sys_clk) begin
    #1;
    core_ack = (core_req === 1'b1) && !core_ack;
    if (core_ack) begin
      core_rdata = 16'ha5c0 | {12'h000, core_cmd[15:12]};
      got_cmd = core_cmd;
      got_ext0 = core_ext0;
      got_ext1 = core_ext1;
    end
    if (brk_exception === 1'b1) exc_cnt++;
    if (resume_pulse === 1'b1) begin
      res_cnt++;
      res_addr = resume_addr;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [19:0] e,
      input logic [19:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic wait_on(input int sel, input logic lvl);
    logic s;
    for (int i = 0; i < 400; i++) begin
      case (sel)
        0: s = tx_ready;
        1: s = rx_valid;
        2: s = target_halted;
        default: s = link_i.halted;
      endcase
      if (s === lvl) return;
      tick(1);
    end
    bad_count++;
    $display("unexpected wait %0d: expected %b seen %b", sel, lvl, s);
    finish_test();
  endtask : wait_on
  task automatic send_word(input logic [15:0] w);
    wait_on(0, 1'b1);
    tx_word = w;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    wait_on(1, 1'b1);
    if (have_exp) chk_val("rx_frame", {3'h0, exp_rx}, {3'h0, rx_frame});
    have_exp = 1'b1;
  endtask : send_word
  task automatic do_cmd(input logic [3:0] op);
    logic [15:0] w;
    logic [15:0] e0;
    logic [1:0] n;
    w = {op, 12'h35a};
    e0 = 16'h1230 + {12'h000, op};
    n = EXT_TBL[2 * op +: 2];
    send_word(w);
    for (int k = 0; k < n; k++) begin
      exp_rx = {STAT_NODATA, 16'h0000};
      send_word(k == 0 ? e0 : 16'hbeef);
    end
    exp_rx = {STAT_NODATA, 16'h0000};
    if (RD_TBL[op]) exp_rx = {STAT_OK, 16'ha5c0 | {12'h000, op}};
    tick(10);
    if (op != 4'h0 && op != 4'hb) begin
      chk_val("core_cmd", {4'h0, w}, {4'h0, got_cmd});
      if (n != 2'h0) chk_val("core_ext0", {4'h0, e0}, {4'h0, got_ext0});
      if (n == 2'h2) chk_val("core_ext1", 20'h0beef, {4'h0, got_ext1});
    end
  endtask : do_cmd
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    have_exp = 1'b0;
    exp_rx = {STAT_NODATA, 16'h0000};
    tick(4);
    srst = 1'b0;
    tick(2);
    chk_bit("pipe_track_0", track_code[0], link_i.pipe_track_0);
    chk_bit("pipe_track_1", track_code[1], link_i.pipe_track_1);
    brk_request = 1'b1;
    enter_debug_instruction = 1'b1;
    tick(4);
    instr_boundary = 1'b1;
    tick(1);
    instr_boundary = 1'b0;
    enter_debug_instruction = 1'b0;
    tick(4);
    chk_val("brk_exception", 20'h1, exc_cnt[19:0]);
    chk_bit("halted", 1'b0, link_i.halted);
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
    brk_request = 1'b0;
    enter_debug_instruction = 1'b1;
    track_code = 2'h2;
    tick(6);
    chk_bit("halted", 1'b0, link_i.halted);
    chk_bit("pipe_track_0", 1'b0, link_i.pipe_track_0);
    instr_boundary = 1'b1;
    tick(1);
    instr_boundary = 1'b0;
    enter_debug_instruction = 1'b0;
    tick(2);
    chk_bit("halted", 1'b1, link_i.halted);
    chk_bit("exec_stall", 1'b1, exec_stall);
    for (int op = 0; op < 12; op++) do_cmd(op[3:0]);
    wait_on(2, 1'b0);
    chk_val("resume count", 20'h1, res_cnt[19:0]);
    chk_val("resume_addr", epc - 20'h00006, res_addr);
    tick(4);
    chk_bit("pt1_dev_oe", 1'b1, link_i.pt1_dev_oe);
    brk_request = 1'b1;
    tick(4);
    instr_boundary = 1'b1;
    tick(1);
    instr_boundary = 1'b0;
    brk_request = 1'b0;
    wait_on(3, 1'b1);
    chk_val("brk_exception", 20'h1, exc_cnt[19:0]);
    have_exp = 1'b0;
    do_cmd(4'h5);
    do_cmd(4'h0);
    finish_test();
  end
endmodule : testbench
